/* File: rtl/pcr_pwm_cycle_config.sv */
// pwm cycle configuration register, compare/reload banks and cycle-wrap interrupt
// Overview of operation
// - the reload bank select bit steers compare byte accesses to compare values (0) or reload values (1).
// - reload values load the compare value only in 9 to 11 bit pwm cycles and do nothing otherwise.
// - the cycle-wrap flag sets when the main counter overflows out of the bit chosen by the length select.
// - hardware and software may set the cycle-wrap flag, only a software write of zero clears it.
// - the array interrupt request is raised while the flag is set and its enable is one.
`include "pcr_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module pcr_pwm_cycle_config
    import pcr_pkg::*;
(
    // clock and reset
    input wire logic CLOCK_I,
    input wire logic SYS_RST_I,
    // avalon-mm slave
    input wire logic [`PCR_ADDR_W-1:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [3:0] AVS_BYTEENABLE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    output logic [31:0] AVS_READDATA_O,
    output logic AVS_WAITREQUEST_O,
    // main counter state and module reload modes, same clock
    input wire logic [15:0] ARRAY_COUNT_I,
    input wire logic ARRAY_COUNT_TICK_I,
    input wire logic [`PCR_NUM_MODULES-1:0] MODULE_PWM_RELOAD_MODE_I,
    // compare values to the modules
    output logic [`PCR_NUM_MODULES*16-1:0] MODULE_COMPARE_VALUE_O,
    // interrupts
    output logic ARRAY_IRQ_O,
    output logic IRQ_O
);
    localparam int NM = `PCR_NUM_MODULES;

    // bus request and state registers
    pcr_bus_req_s req;
    pcr_cfg_s cfg_reg;
    logic waitreq_reg;
    logic [31:0] readdata_reg;
    logic [NM-1:0][15:0] cmp_reg;
    logic [NM-1:0][15:0] reload_reg;
    logic irq_status_reg;
    logic irq_mask_reg;
    logic array_irq_reg;
    logic irq_reg;

    // decode and datapath nets
    logic acc;
    logic wr_acc;
    logic rd_take;
    logic lane0;
    logic [7:0] idx;
    logic [7:0] wbyte;
    logic [10:0] len_mask;
    logic wrap_evt;
    logic [31:0] rd_data;

    // bus request bundle
    assign req.address = AVS_ADDRESS_I;
    assign req.read = AVS_READ_I;
    assign req.write = AVS_WRITE_I;
    assign req.byteenable = AVS_BYTEENABLE_I;
    assign req.writedata = AVS_WRITEDATA_I;

    // an access completes in the cycle waitrequest is low
    assign acc = (req.read | req.write) & ~waitreq_reg;
    assign wr_acc = acc & req.write;
    assign lane0 = req.byteenable[0];
    assign idx = req.address[9:2];
    assign wbyte = req.writedata[7:0];

    // read data fetched as the request is first seen, so it stands in the low cycle
    assign rd_take = req.read & waitreq_reg;

    // cycle length mask per select code
    always_comb begin
        unique case (cfg_reg.cycle_length_select)
            PCR_LEN_8: len_mask = `PCR_LEN8_MASK;
            PCR_LEN_9: len_mask = `PCR_LEN9_MASK;
            PCR_LEN_10: len_mask = `PCR_LEN10_MASK;
            PCR_LEN_11: len_mask = `PCR_LEN11_MASK;
        endcase
    end

    // overflow out of the selected counter bit on the next increment
    assign wrap_evt = ARRAY_COUNT_TICK_I & ((ARRAY_COUNT_I[10:0] & len_mask) == len_mask);

    // waitrequest: one wait cycle, then a single low cycle
    always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            waitreq_reg <= 1'b1;
        end else if ((req.read | req.write) & waitreq_reg) begin
            waitreq_reg <= 1'b0;
        end else begin
            waitreq_reg <= 1'b1;
        end
    end

    // read data mux
    always_comb begin
        rd_data = 32'h0000_0000;
        if (idx == `PCR_CFG_IDX) begin
            rd_data[7:0] = {cfg_reg.reload_bank_select, cfg_reg.cycle_wrap_irq_enable,
                            cfg_reg.cycle_wrap_flag, 3'b000, cfg_reg.cycle_length_select};
        end else if (idx == `PCR_IRQ_STATUS_IDX) begin
            rd_data[0] = irq_status_reg;
        end else if (idx == `PCR_IRQ_MASK_IDX) begin
            rd_data[0] = irq_mask_reg;
        end
        // compare bytes follow the bank select
        for (int n = 0; n < NM; n++) begin
            if (idx == `PCR_CMP_BASE_IDX + 8'(2 * n)) begin
                rd_data[7:0] = cfg_reg.reload_bank_select ? reload_reg[n][7:0]
                                                          : cmp_reg[n][7:0];
            end else if (idx == `PCR_CMP_BASE_IDX + 8'(2 * n + 1)) begin
                rd_data[7:0] = cfg_reg.reload_bank_select ? reload_reg[n][15:8]
                                                          : cmp_reg[n][15:8];
            end
        end
    end

    // read data register, valid while waitrequest is low
    always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            readdata_reg <= 32'h0000_0000;
        end else if (rd_take) begin
            readdata_reg <= rd_data;
        end
    end

    // config register; hardware set wins over a software clear
    always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            cfg_reg <= pcr_cfg_s'(`PCR_CFG_RESET);
        end else begin
            if (wr_acc & lane0 & (idx == `PCR_CFG_IDX)) begin
                cfg_reg.reload_bank_select <= wbyte[`PCR_BIT_RELOAD_SEL];
                cfg_reg.cycle_wrap_irq_enable <= wbyte[`PCR_BIT_IRQ_EN];
                cfg_reg.cycle_wrap_flag <= wbyte[`PCR_BIT_WRAP_FLAG];
                cfg_reg.cycle_length_select <= pcr_len_e'(wbyte[1:0]);
            end
            if (wrap_evt) begin
                cfg_reg.cycle_wrap_flag <= 1'b1;
            end
            cfg_reg.unused <= 3'b000;
        end
    end

    // compare and reload banks
    always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            cmp_reg <= '0;
            reload_reg <= '0;
        end else begin
            for (int n = 0; n < NM; n++) begin
                // reload only in 9 to 11 bit cycles
                if (wrap_evt & (cfg_reg.cycle_length_select != PCR_LEN_8)
                    & MODULE_PWM_RELOAD_MODE_I[n]) begin
                    cmp_reg[n] <= reload_reg[n];
                end
                if (wr_acc & lane0 & (idx == `PCR_CMP_BASE_IDX + 8'(2 * n))) begin
                    if (cfg_reg.reload_bank_select) begin
                        reload_reg[n][7:0] <= wbyte;
                    end else begin
                        cmp_reg[n][7:0] <= wbyte;
                    end
                end
                if (wr_acc & lane0 & (idx == `PCR_CMP_BASE_IDX + 8'(2 * n + 1))) begin
                    if (cfg_reg.reload_bank_select) begin
                        reload_reg[n][15:8] <= wbyte;
                    end else begin
                        cmp_reg[n][15:8] <= wbyte;
                    end
                end
            end
        end
    end

    // sticky status, write one to clear, set wins
    always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            irq_status_reg <= 1'b0;
            irq_mask_reg <= 1'b0;
        end else begin
            if (wr_acc & lane0 & (idx == `PCR_IRQ_MASK_IDX)) begin
                irq_mask_reg <= wbyte[0];
            end
            if (wrap_evt) begin
                irq_status_reg <= 1'b1;
            end else if (wr_acc & lane0 & (idx == `PCR_IRQ_STATUS_IDX) & wbyte[0]) begin
                irq_status_reg <= 1'b0;
            end
        end
    end

    // interrupt outputs
    always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            array_irq_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            array_irq_reg <= cfg_reg.cycle_wrap_flag & cfg_reg.cycle_wrap_irq_enable;
            irq_reg <= irq_status_reg & irq_mask_reg;
        end
    end

    // bus outputs
    assign AVS_READDATA_O = readdata_reg;
    assign AVS_WAITREQUEST_O = waitreq_reg;

    // compare values to the modules
    assign MODULE_COMPARE_VALUE_O = cmp_reg;

    // interrupt outputs
    assign ARRAY_IRQ_O = array_irq_reg;
    assign IRQ_O = irq_reg;
endmodule : pcr_pwm_cycle_config
`default_nettype wire

/* File: rtl/pcr_defines.svh */
// offsets, field positions, reset values, length masks and sizes of the pwm cycle config block
`ifndef PCR_DEFINES_SVH
`define PCR_DEFINES_SVH
// word indices (byte address = index * 4)
`define PCR_CFG_IDX 8'hdf
`define PCR_IRQ_STATUS_IDX 8'h10
`define PCR_IRQ_MASK_IDX 8'h11
`define PCR_CMP_BASE_IDX 8'h40
// field positions of the config register
`define PCR_BIT_RELOAD_SEL 7
`define PCR_BIT_IRQ_EN 6
`define PCR_BIT_WRAP_FLAG 5
`define PCR_CFG_RESET 8'h00
// cycle length low-bit masks, one per select code
`define PCR_LEN8_MASK 11'h0ff
`define PCR_LEN9_MASK 11'h1ff
`define PCR_LEN10_MASK 11'h3ff
`define PCR_LEN11_MASK 11'h7ff
// structure
`define PCR_NUM_MODULES 6
`define PCR_ADDR_W 10
`endif

/* File: rtl/pcr_pkg.sv */
// types of the pwm cycle config block
package pcr_pkg;
    typedef enum logic [1:0] {
        PCR_LEN_8 = 2'b00,
        PCR_LEN_9 = 2'b01,
        PCR_LEN_10 = 2'b10,
        PCR_LEN_11 = 2'b11
    } pcr_len_e;

    typedef struct packed {
        logic reload_bank_select;
        logic cycle_wrap_irq_enable;
        logic cycle_wrap_flag;
        logic [2:0] unused;
        pcr_len_e cycle_length_select;
    } pcr_cfg_s;

    typedef struct packed {
        logic [9:0] address;
        logic read;
        logic write;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } pcr_bus_req_s;
endpackage : pcr_pkg

/* File: verification/pcr_cycle_monitor.sv */
// port checker of the pwm cycle config block
`timescale 1ns/10ps
`default_nettype none
module pcr_cycle_monitor (
    // clock, reset and bus
    input wire logic CLOCK_I,
    input wire logic SYS_RST_I,
    input wire logic [9:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_READDATA_O,
    input wire logic AVS_WAITREQUEST_O,
    // counter, modules and interrupts
    input wire logic [15:0] ARRAY_COUNT_I,
    input wire logic ARRAY_COUNT_TICK_I,
    input wire logic [5:0] MODULE_PWM_RELOAD_MODE_I,
    input wire logic [95:0] MODULE_COMPARE_VALUE_O,
    input wire logic ARRAY_IRQ_O,
    input wire logic IRQ_O
);
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (SYS_RST_I);
    // accepted write, and a tick that may end a cycle of any length
    wire logic wr_done = AVS_WRITE_I && !AVS_WAITREQUEST_O;
    wire logic wrap = ARRAY_COUNT_TICK_I && ARRAY_COUNT_I[7:0] == 8'hff;
    // cause of each array irq edge, of each irq rise and of each compare change; unused config bits read zero
    a_irq_rise_cause: assert property ($rose(ARRAY_IRQ_O) |-> $past(wrap, 2) || $past(wr_done, 2))
        else $error("array irq rose without wrap or write");
    a_irq_fall_cause: assert property ($fell(ARRAY_IRQ_O) |-> $past(wr_done, 2))
        else $error("array irq fell without a write");
    a_status_rise: assert property ($rose(IRQ_O) |-> $past(wrap, 2) || $past(wr_done, 2))
        else $error("irq rose without wrap or write");
    a_compare_cause: assert property (!$stable(MODULE_COMPARE_VALUE_O) |->
        $past(wr_done) || $past(wrap && |MODULE_PWM_RELOAD_MODE_I))
        else $error("compare value changed without cause");
    a_unused_zero: assert property (AVS_READ_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I[9:2] == 8'hdf
        |-> AVS_READDATA_O[4:2] == 3'h0)
        else $error("unused config bits not zero");
    // bus answer timing, then covers of array irq rise, reload and config read
    a_wait_one_cycle: assert property (!AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
        else $error("waitrequest low too long");
    a_wait_answers: assert property ((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
        else $error("request not answered");
    a_wait_idle: assert property (!AVS_READ_I && !AVS_WRITE_I && AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
        else $error("answer without request");
    c_irq: cover property ($rose(ARRAY_IRQ_O));
    c_reload: cover property (wrap && |MODULE_PWM_RELOAD_MODE_I);
    c_cfg_read: cover property (AVS_READ_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I[9:2] == 8'hdf);
endmodule : pcr_cycle_monitor
bind pcr_pwm_cycle_config pcr_cycle_monitor i_mon (.CLOCK_I(CLOCK_I), .SYS_RST_I(SYS_RST_I),
    .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
    .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
    .ARRAY_COUNT_I(ARRAY_COUNT_I), .ARRAY_COUNT_TICK_I(ARRAY_COUNT_TICK_I),
    .MODULE_PWM_RELOAD_MODE_I(MODULE_PWM_RELOAD_MODE_I),
    .MODULE_COMPARE_VALUE_O(MODULE_COMPARE_VALUE_O), .ARRAY_IRQ_O(ARRAY_IRQ_O), .IRQ_O(IRQ_O));
`default_nettype wire

/* File: verification/testbench.sv */
// self-checking bench of the pwm cycle config block
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [9:0] addr = 10'h000;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [15:0] cnt = 16'h0;
    logic tick = 1'b0;
    logic [5:0] mode = 6'h00;
    logic [31:0] rdata;
    logic waitreq;
    logic [95:0] cmp;
    logic airq;
    logic irq;
    logic [31:0] q;
    int n_mismatch = 0;
    int samples_checked = 0;
    pcr_pwm_cycle_config i_dut (.CLOCK_I(clk), .SYS_RST_I(rst), .AVS_ADDRESS_I(addr),
        .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_BYTEENABLE_I(4'h1), .AVS_WRITEDATA_I(wdata),
        .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq), .ARRAY_COUNT_I(cnt),
        .ARRAY_COUNT_TICK_I(tick), .MODULE_PWM_RELOAD_MODE_I(mode),
        .MODULE_COMPARE_VALUE_O(cmp), .ARRAY_IRQ_O(airq), .IRQ_O(irq));
    // 125 MHz clock
    always #4 clk = ~clk;
    // compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // one bus access, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        addr <= a;
        wdata <= {24'h0, d};
        wr <= w;
        rd <= !w;
        do begin
            @(posedge clk);
            n++;
        end while (waitreq !== 1'b0 && n < 100);
        if (n >= 100)
            n_mismatch++;
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus
    // read and compare
    task automatic rdc(input logic [9:0] a, input logic [31:0] e);
        bus(1'b0, a, 8'h00);
        chk(q, e);
    endtask : rdc
    // one counter tick, then wait for the interrupt outputs to settle
    task automatic wrap_at(input logic [15:0] c);
        @(posedge clk);
        cnt <= c;
        tick <= 1'b1;
        @(posedge clk);
        tick <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : wrap_at
    // verdict and end of run
    task automatic final_report;
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : final_report
    // watchdog
    initial begin
        #40000;
        n_mismatch++;
        final_report();
    end
    // main sequence
    initial begin
        logic [15:0] m;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rdc(10'h37c, 32'h0);
        rdc(10'h040, 32'h0);
        rdc(10'h200, 32'h0);
        bus(1'b1, 10'h044, 8'h01);
        bus(1'b1, 10'h37c, 8'hff);
        rdc(10'h37c, 32'he3);
        bus(1'b1, 10'h37c, 8'h00);
        rdc(10'h37c, 32'h0);
        // each cycle length: no flag one bit short, flag at the full count
        for (int s = 0; s < 4; s++) begin
            m = 16'((1 << (8 + s)) - 1);
            bus(1'b1, 10'h37c, 8'h40 | 8'(s));
            wrap_at(m >> 1);
            chk({31'h0, airq}, 32'h0);
            wrap_at(m);
            chk({31'h0, airq}, 32'h1);
            chk({31'h0, irq}, 32'h1);
            rdc(10'h37c, 32'h60 | 32'(s));
            rdc(10'h040, 32'h1);
            bus(1'b1, 10'h040, 8'h01);
            bus(1'b1, 10'h37c, 8'h40 | 8'(s));
            rdc(10'h37c, 32'h40 | 32'(s));
            chk({31'h0, irq}, 32'h0);
        end
        // flag without enable does not raise the array interrupt
        bus(1'b1, 10'h37c, 8'h00);
        wrap_at(16'h00ff);
        chk({31'h0, airq}, 32'h0);
        rdc(10'h37c, 32'h20);
        // status stays set; clearing the mask drops the level interrupt
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, 10'h044, 8'h00);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        // reload bank against compare bank of module 0
        mode <= 6'h01;
        bus(1'b1, 10'h37c, 8'h81);
        bus(1'b1, 10'h100, 8'h34);
        bus(1'b1, 10'h104, 8'h12);
        bus(1'b1, 10'h37c, 8'h01);
        bus(1'b1, 10'h100, 8'h78);
        bus(1'b1, 10'h104, 8'h56);
        rdc(10'h104, 32'h56);
        chk(32'(cmp[15:0]), 32'h5678);
        bus(1'b1, 10'h37c, 8'h80);
        rdc(10'h100, 32'h34);
        wrap_at(16'h00ff);
        chk(32'(cmp[15:0]), 32'h5678);
        bus(1'b1, 10'h37c, 8'h01);
        wrap_at(16'h01ff);
        chk(32'(cmp[15:0]), 32'h1234);
        final_report();
    end
endmodule : testbench
`default_nettype wire
